// File: rtl/bis_defines.svh
// offsets, field positions, reset values and fixed codes of the bridge window block
// Operation
// - latency byte, top byte of word 0x18, reads zero and ignores writes
// - low nibbles of I/O base and limit bytes read as one, read-only
// - base field gives bound bits 15:12, bits 11:0 zero, resets zero
// - limit field gives bound bits 15:12, bits 11:0 all ones, resets zero
// - bound bits 31:16 come from separate upper-half base and limit register
// - I/O request forwarded only when address lies inside programmed bounds
// - status bits 21, 23, 26:25 read zero, read-only
// - bit 24 set on secondary parity error seen or forwarded as requester
// - bit 24 never set while parity error response enable is clear
// - bit 27 set when completing a request with completer abort
// - bit 28 set on received completion with completer abort status
// - bit 29 set on received completion with unsupported request status
// - bit 30 set on sent fatal or nonfatal message while system error enable
// - bit 31 set on received poisoned packet on secondary side
`ifndef BIS_DEFINES_SVH
`define BIS_DEFINES_SVH

`define BIS_OFS_BUS_WORD   8'h18
`define BIS_OFS_IO_STATUS  8'h1c
`define BIS_OFS_IO_UPPER   8'h30
`define BIS_OFS_CTRL       8'h40

`define BIS_LAT_LSB        24
`define BIS_BASE_CODE_LSB  0
`define BIS_BASE_NIB_LSB   4
`define BIS_LIM_CODE_LSB   8
`define BIS_LIM_NIB_LSB    12
`define BIS_IO32_CODE      4'h1
`define BIS_BASE_FILL      12'h000
`define BIS_LIMIT_FILL     12'hfff
`define BIS_NIB_RESET      4'h0
`define BIS_UPPER_RESET    16'h0000

`define BIS_ST_PERR        24
`define BIS_ST_SIG_TA      27
`define BIS_ST_RX_TA       28
`define BIS_ST_RX_MA       29
`define BIS_ST_SERR        30
`define BIS_ST_POISON      31

`define BIS_CTRL_PERR_EN   0
`define BIS_CTRL_SERR_EN   1

`endif

// File: rtl/bis_pkg.sv
// types shared by the bridge window block
package bis_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} bis_apb_req_type;

	typedef struct packed {
		logic parity_err;
		logic sent_cpl_abort;
		logic rx_cpl_abort;
		logic rx_cpl_unsupported;
		logic sent_err_msg;
		logic rx_poisoned;
	} bis_event_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} bis_io_req_type;

	typedef struct packed {
		logic        valid;
		logic        forward;
	} bis_io_dec_type;

	typedef struct packed {
		logic        perr;
		logic        sig_ta;
		logic        rx_ta;
		logic        rx_ma;
		logic        serr;
		logic        poison;
	} bis_flags_type;

	typedef struct packed {
		logic [3:0]     base_nib;
		logic [3:0]     limit_nib;
		logic [15:0]    base_upper;
		logic [15:0]    limit_upper;
		logic           perr_resp_en;
		logic           serr_en;
		bis_flags_type  flags;
		logic [31:0]    prdata;
		logic           pslverr;
		bis_io_dec_type dec;
	} bis_state_type;

endpackage

// File: rtl/bis_regs.sv
// bridge I/O window, secondary status flags and forwarding decision behind APB
`timescale 1ns/100ps
`include "bis_defines.svh"

module bis_regs (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                srst,
	// apb slave
	input  wire bis_pkg::bis_apb_req_type apb_req,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// secondary-side traffic events, one-cycle pulses
	input  wire bis_pkg::bis_event_type   events,
	// I/O forwarding request and registered decision
	input  wire bis_pkg::bis_io_req_type  io_req,
	output bis_pkg::bis_io_dec_type       io_dec
);

	bis_pkg::bis_state_type state;
	bis_pkg::bis_state_type next_state;

	// compose a 32-bit window bound
	function automatic logic [31:0] make_bound(
		input logic [15:0] upper,
		input logic [3:0]  nib,
		input logic [11:0] fill
	);
		make_bound = {upper, nib, fill};
	endfunction

	logic [31:0] lower_bound;
	logic [31:0] upper_bound;
	logic        setup;
	logic        access_wr;
	logic        mapped;
	logic [31:0] read_word;
	logic [31:0] status_word;
	logic [31:0] wdata;

	assign lower_bound = make_bound(state.base_upper, state.base_nib,
		`BIS_BASE_FILL);
	assign upper_bound = make_bound(state.limit_upper, state.limit_nib,
		`BIS_LIMIT_FILL);

	assign setup     = apb_req.psel & ~apb_req.penable;
	assign access_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign wdata     = apb_req.pwdata;

	// status word with I/O base and limit bytes, reserved and legacy bits stay zero
	always_comb begin
		status_word                 = 32'h0000_0000;
		status_word[`BIS_ST_PERR]   = state.flags.perr;
		status_word[`BIS_ST_SIG_TA] = state.flags.sig_ta;
		status_word[`BIS_ST_RX_TA]  = state.flags.rx_ta;
		status_word[`BIS_ST_RX_MA]  = state.flags.rx_ma;
		status_word[`BIS_ST_SERR]   = state.flags.serr;
		status_word[`BIS_ST_POISON] = state.flags.poison;
		status_word[`BIS_BASE_CODE_LSB +: 4] = `BIS_IO32_CODE;
		status_word[`BIS_BASE_NIB_LSB +: 4]  = state.base_nib;
		status_word[`BIS_LIM_CODE_LSB +: 4]  = `BIS_IO32_CODE;
		status_word[`BIS_LIM_NIB_LSB +: 4]   = state.limit_nib;
	end

	// read mux
	always_comb begin
		read_word = 32'h0000_0000;
		mapped    = 1'b1;
		case (apb_req.paddr)
			`BIS_OFS_BUS_WORD: begin
				// latency byte hardwired zero, other bytes not held here
				read_word[`BIS_LAT_LSB +: 8] = 8'h00;
			end
			`BIS_OFS_IO_STATUS: begin
				read_word = status_word;
			end
			`BIS_OFS_IO_UPPER: begin
				read_word = {state.limit_upper, state.base_upper};
			end
			`BIS_OFS_CTRL: begin
				read_word[`BIS_CTRL_PERR_EN] = state.perr_resp_en;
				read_word[`BIS_CTRL_SERR_EN] = state.serr_en;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_state = state;

		// read data and error captured in setup, shown in access
		if (setup) begin
			next_state.prdata  = apb_req.pwrite ? 32'h0000_0000 : read_word;
			next_state.pslverr = ~mapped;
		end

		// writes take effect at the access edge; word 0x18 ignores them
		if (access_wr) begin
			case (apb_req.paddr)
				`BIS_OFS_IO_STATUS: begin
					next_state.base_nib  = wdata[`BIS_BASE_NIB_LSB +: 4];
					next_state.limit_nib = wdata[`BIS_LIM_NIB_LSB +: 4];
					// write one clears
					if (wdata[`BIS_ST_PERR]) begin
						next_state.flags.perr = 1'b0;
					end
					if (wdata[`BIS_ST_SERR]) begin
						next_state.flags.serr = 1'b0;
					end
					if (wdata[`BIS_ST_POISON]) begin
						next_state.flags.poison = 1'b0;
					end
				end
				`BIS_OFS_IO_UPPER: begin
					next_state.base_upper  = wdata[15:0];
					next_state.limit_upper = wdata[31:16];
				end
				`BIS_OFS_CTRL: begin
					next_state.perr_resp_en = wdata[`BIS_CTRL_PERR_EN];
					next_state.serr_en      = wdata[`BIS_CTRL_SERR_EN];
				end
				default: begin
					next_state.pslverr = state.pslverr;
				end
			endcase
		end

		// events after clears so a same-cycle event keeps the flag set
		if (events.parity_err && state.perr_resp_en) begin
			next_state.flags.perr = 1'b1;
		end
		if (events.sent_cpl_abort) begin
			next_state.flags.sig_ta = 1'b1;
		end
		if (events.rx_cpl_abort) begin
			next_state.flags.rx_ta = 1'b1;
		end
		if (events.rx_cpl_unsupported) begin
			next_state.flags.rx_ma = 1'b1;
		end
		if (events.sent_err_msg && state.serr_en) begin
			next_state.flags.serr = 1'b1;
		end
		if (events.rx_poisoned) begin
			next_state.flags.poison = 1'b1;
		end

		// forwarding decision one cycle after the request
		next_state.dec.valid   = io_req.valid;
		next_state.dec.forward = io_req.valid &&
			(io_req.addr >= lower_bound) &&
			(io_req.addr <= upper_bound);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign prdata  = state.prdata;
	assign pslverr = state.pslverr & apb_req.psel & apb_req.penable;
	assign pready  = apb_req.psel & apb_req.penable;
	assign io_dec  = state.dec;

endmodule

// File: verification/bis_regs_monitor.sv
// concurrent checks on the bridge window block ports
`timescale 1ns/100ps
module bis_regs_monitor (
	// clock and reset
	input wire logic                     clk_sys,
	input wire logic                     srst,
	// watched ports
	input wire bis_pkg::bis_apb_req_type apb_req,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire bis_pkg::bis_event_type   events,
	input wire bis_pkg::bis_io_req_type  io_req,
	input wire bis_pkg::bis_io_dec_type  io_dec
);
	wire logic acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
	wire logic rd1c = acc && apb_req.paddr == 8'h1c;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	lat_zero_a: assert property (
		acc && apb_req.paddr == 8'h18 |-> prdata[31:24] == 8'h00)
		else $error("latency byte");
	io_code_a: assert property (
		rd1c |-> prdata[3:0] == 4'h1 && prdata[11:8] == 4'h1)
		else $error("io code");
	rsv_zero_a: assert property (
		rd1c |-> prdata[23:16] == 8'h00 && prdata[26:25] == 2'h0)
		else $error("reserved bits");
	dec_follow_a: assert property (io_req.valid |=> io_dec.valid)
		else $error("no decision");
	dec_idle_a: assert property (!io_req.valid |=> !io_dec.valid)
		else $error("spurious decision");
	sig_ta_a: assert property (events.sent_cpl_abort ##[2:8] rd1c |-> prdata[27])
		else $error("bit 27");
	rx_ta_a: assert property (events.rx_cpl_abort ##[2:8] rd1c |-> prdata[28])
		else $error("bit 28");
	rx_ma_a: assert property (events.rx_cpl_unsupported ##[2:8] rd1c |-> prdata[29])
		else $error("bit 29");
endmodule
bind bis_regs bis_regs_monitor bis_regs_monitor_inst (.clk_sys, .srst, .apb_req, .prdata,
	.pready, .pslverr, .events, .io_req, .io_dec);

// File: verification/bis_sec_model.sv
// secondary-side traffic source making one-cycle event pulses
`timescale 1ns/100ps
module bis_sec_model (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	// bench command in, pulses out
	input  wire bis_pkg::bis_event_type cmd,
	output bis_pkg::bis_event_type      events
);
	always_ff @(posedge clk_sys) begin
		events <= srst ? '0 : cmd;
	end
endmodule

// File: verification/tb.sv
// self-checking bench for the bridge window block
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
	logic                     clk_sys;
	logic                     srst;
	bis_pkg::bis_apb_req_type apb_req;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	bis_pkg::bis_event_type   cmd;
	bis_pkg::bis_event_type   events;
	bis_pkg::bis_io_req_type  io_req;
	bis_pkg::bis_io_dec_type  io_dec;
	int                       failures = 0;
	int                       num_checks = 0;
	int                       cyc = 0;
	logic [31:0]              d;
	logic                     e;
	bis_regs bis_regs_inst (.clk_sys, .srst, .apb_req, .prdata, .pready, .pslverr,
		.events, .io_req, .io_dec);
	bis_sec_model bis_sec_model_inst (.clk_sys, .srst, .cmd, .events);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			failures++;
			test_done;
		end
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		apb_req <= '{1'b1, 1'b0, w, a, wd};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		d = prdata;
		e = pslverr;
		apb_req <= '0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		`CHK(d, x)
	endtask
	task automatic fire(input bis_pkg::bis_event_type v);
		cmd <= v;
		@(posedge clk_sys);
		cmd <= '0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic io(input logic [31:0] a, input logic x);
		io_req <= '{1'b1, a};
		@(posedge clk_sys);
		io_req <= '0;
		@(negedge clk_sys);
		`CHK(io_dec, {1'b1, x})
		@(posedge clk_sys);
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		apb_req = '0;
		cmd = '0;
		io_req = '0;
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rd(8'h1c, 32'h0000_0101);
		xfer(1'b1, 8'h18, 32'hffff_ffff);
		rd(8'h18, 32'h0000_0000);
		xfer(1'b1, 8'h1c, 32'h06ff_5020);
		rd(8'h1c, 32'h0000_5121);
		xfer(1'b1, 8'h30, 32'h0003_0001);
		io(32'h0001_1fff, 1'b0);
		io(32'h0001_2000, 1'b1);
		io(32'h0003_5fff, 1'b1);
		io(32'h0003_6000, 1'b0);
		io(32'h0000_3000, 1'b0);
		fire(6'h22);
		rd(8'h1c, 32'h0000_5121);
		xfer(1'b1, 8'h40, 32'h0000_0003);
		fire(6'h3f);
		rd(8'h1c, 32'hf900_5121);
		xfer(1'b1, 8'h1c, 32'h0000_5020);
		rd(8'h1c, 32'hf900_5121);
		xfer(1'b1, 8'h1c, 32'hff00_5020);
		rd(8'h1c, 32'h3800_5121);
		xfer(1'b0, 8'h24, 32'h0);
		`CHK(e, 1'b1)
		test_done;
	end
endmodule
